// [common/lsa_defines.vh]
`ifndef LSA_DEFINES_VH
`define LSA_DEFINES_VH
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define LSA_COND_HI      31
`define LSA_COND_LO      28
`define LSA_CLASS_HI     27
`define LSA_CLASS_LO     26
`define LSA_IMM_BIT      25
`define LSA_OPC_HI       24
`define LSA_OPC_LO       21
`define LSA_SET_BIT      20
`define LSA_RN_HI        19
`define LSA_RN_LO        16
`define LSA_RD_HI        15
`define LSA_RD_LO        12
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define LSA_OPC_MVN      4'hf
`define LSA_OPC_OR       4'hc
`define LSA_OPC_RSUB     4'h3
`define LSA_OPC_RSUBC    4'h7
`define LSA_OPC_SUBC     4'h6
// ----------------------------------------
// Status word layout and reset values
// ----------------------------------------
`define LSA_N_BIT        31
`define LSA_Z_BIT        30
`define LSA_C_BIT        29
`define LSA_V_BIT        28
`define LSA_PC_INDEX     4'hf
`define LSA_MODE_HI      4
`define LSA_MODE_LO      0
`define LSA_MODE_USER    5'h10
`define LSA_MODE_SYSTEM  5'h1f
`define LSA_STATUS_RESET 32'h000000d3
`define LSA_PC_RESET     32'h00000000
`endif

// [rtl/lsa_alu.v]
// Design decision made here: the strobed register write port.
`timescale 1ns/100ps
`default_nettype none
`include "lsa_defines.vh"
// Summary of operation
// RQ1: Move-inverted writes one's complement of shifted operand to destination.
// RQ2: OR writes first operand OR shifted operand to destination.
// RQ3: Reverse subtract writes shifted operand minus first operand.
// RQ4: Reverse subtract with carry also subtracts inverse of carry.
// RQ5: Subtract with carry: first operand minus shifted minus inverse carry.
// RQ6: Failed condition changes no register and no flag.
// RQ7: Flag update with PC destination writes PC and restores saved status word.
// RQ8: No flag update with PC destination writes PC, flags untouched.
// RQ9: Software avoids the restoring form in user or system mode.
// RQ10: Flag update, non-PC destination: N from bit 31, Z on zero result.
// RQ11: Move-inverted with update takes carry from shifter, keeps overflow.
// RQ12: Subtracts with update: carry is not-borrow, overflow is signed overflow.
// RQ13: Bit 25 selects immediate or register shifted operand.
// RQ14: Opcodes 1111, 1100, 0011, 0111, 0110; bit 20 is flag update.
// RQ15: Encoder places zeros in bits 19..16 for move-inverted.
// RQ16: OR with update changes only N, Z and C, carry from shifter.
// RQ17: Condition bits 31..28, bits 27..26 zero, destination bits 15..12.
// RQ18: OR with update leaves overflow unchanged.
module lsa_alu #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clock_i,
  input  wire         rst_i,
  // Instruction issue
  input  wire         issue_i,
  input  wire [31:0]  instr_i,
  // Operands from register file and shifter
  input  wire [W-1:0] first_operand_register_i,
  input  wire [W-1:0] shift_imm_operand_i,
  input  wire         shift_imm_carry_i,
  input  wire [W-1:0] shift_reg_operand_i,
  input  wire         shift_reg_carry_i,
  // Saved status word of current mode
  input  wire [31:0]  saved_status_word_i,
  // Register file write port
  output reg          rd_we_o,
  output reg  [3:0]   rd_index_o,
  output reg  [W-1:0] rd_data_o,
  // Program counter and status
  output reg  [W-1:0] program_counter_o,
  output reg          pc_load_o,
  output reg  [31:0]  current_status_word_o,
  // Decode status
  output reg          executed_o,
  output reg          unpredictable_o
);
  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  reg  [31:0] current_status_word_q;
  wire        c_flag   = current_status_word_q[`LSA_C_BIT];
  wire        v_flag   = current_status_word_q[`LSA_V_BIT];
  wire [3:0] cond     = instr_i[`LSA_COND_HI:`LSA_COND_LO];    // RQ17
  wire [1:0] klass    = instr_i[`LSA_CLASS_HI:`LSA_CLASS_LO];  // RQ17
  wire       imm_sel  = instr_i[`LSA_IMM_BIT];
  wire [3:0] opc      = instr_i[`LSA_OPC_HI:`LSA_OPC_LO];
  wire       set_fl   = instr_i[`LSA_SET_BIT];                 // RQ14
  wire [3:0] rd_idx   = instr_i[`LSA_RD_HI:`LSA_RD_LO];        // RQ17
  wire       dest_pc  = (rd_idx == `LSA_PC_INDEX);

  // Operation kind
  localparam [1:0] KIND_NONE = 2'h0;
  localparam [1:0] KIND_MVN  = 2'h1;
  localparam [1:0] KIND_OR   = 2'h2;
  localparam [1:0] KIND_SUB  = 2'h3;

  reg [1:0] kind;
  always @* begin
    case (opc)  // RQ14
      `LSA_OPC_MVN:   kind = KIND_MVN;
      `LSA_OPC_OR:    kind = KIND_OR;
      `LSA_OPC_RSUB:  kind = KIND_SUB;
      `LSA_OPC_RSUBC: kind = KIND_SUB;
      `LSA_OPC_SUBC:  kind = KIND_SUB;
      default:        kind = KIND_NONE;
    endcase
  end
  wire       known    = (klass == 2'b00) & (kind != KIND_NONE);  // RQ17

  // ----------------------------------------
  // Shifted operand select
  // ----------------------------------------
  reg [W-1:0] shop;
  reg         shcar;
  always @* begin
    if (imm_sel) begin
      shop  = shift_imm_operand_i;  // RQ13
      shcar = shift_imm_carry_i;
    end else begin
      shop  = shift_reg_operand_i;  // RQ13
      shcar = shift_reg_carry_i;
    end
  end

  // ----------------------------------------
  // Condition evaluation
  // ----------------------------------------
  wire [3:0] nzcv = current_status_word_q[`LSA_N_BIT:`LSA_V_BIT];
  wire       cpass;
  lsa_cond_check u_cond (
    .cond_i (cond),
    .nzcv_i (nzcv),
    .pass_o (cpass)
  );

  // ----------------------------------------
  // Subtractor
  // ----------------------------------------
  reg  [W-1:0] sub_a;
  reg  [W-1:0] sub_b;
  reg          sub_cin;
  // Operand order and carry-in per subtract variant
  always @* begin
    case (opc)
      `LSA_OPC_RSUB: begin
        sub_a   = shop;  // RQ3
        sub_b   = first_operand_register_i;
        sub_cin = 1'b1;
      end
      `LSA_OPC_RSUBC: begin
        sub_a   = shop;  // RQ4
        sub_b   = first_operand_register_i;
        sub_cin = c_flag;
      end
      `LSA_OPC_SUBC: begin
        sub_a   = first_operand_register_i;  // RQ5
        sub_b   = shop;
        sub_cin = c_flag;
      end
      default: begin
        sub_a   = first_operand_register_i;
        sub_b   = shop;
        sub_cin = 1'b1;
      end
    endcase
  end
  wire [W-1:0] diff;
  wire         no_borrow;
  wire         ovf;
  lsa_sub_unit #(
    .W (W)
  ) u_sub (
    .a_i         (sub_a),
    .b_i         (sub_b),
    .carry_i     (sub_cin),
    .diff_o      (diff),
    .no_borrow_o (no_borrow),
    .ovf_o       (ovf)
  );

  // ----------------------------------------
  // Result and flag computation
  // ----------------------------------------
  reg [W-1:0] result;
  reg         new_c;
  reg         new_v;
  always @* begin
    result = {W{1'b0}};
    new_c  = c_flag;
    new_v  = v_flag;
    case (kind)
      KIND_MVN: begin
        result = ~shop;  // RQ1
        new_c  = shcar;  // RQ11
        new_v  = v_flag;  // RQ11
      end
      KIND_OR: begin
        result = first_operand_register_i | shop;  // RQ2
        new_c  = shcar;  // RQ16
        new_v  = v_flag;  // RQ18
      end
      KIND_SUB: begin
        result = diff;  // RQ3 RQ4 RQ5
        new_c  = no_borrow;  // RQ12
        new_v  = ovf;  // RQ12
      end
      default: begin
        result = {W{1'b0}};
        new_c  = c_flag;
        new_v  = v_flag;
      end
    endcase
  end

  // ----------------------------------------
  // Issue qualification
  // ----------------------------------------
  wire        fire          = issue_i & known & cpass;  // RQ6
  wire        restore       = fire & set_fl & dest_pc;  // RQ7
  wire        flag_up       = fire & set_fl & ~dest_pc;  // RQ10
  wire [4:0]  mode          = current_status_word_q[`LSA_MODE_HI:`LSA_MODE_LO];
  wire        no_saved_word = (mode == `LSA_MODE_USER) | (mode == `LSA_MODE_SYSTEM);

  // ----------------------------------------
  // Next status word
  // ----------------------------------------
  reg         flag_n_d;
  reg         flag_z_d;
  reg         flag_c_d;
  reg         flag_v_d;
  reg  [31:0] status_d;
  always @* begin
    flag_n_d = current_status_word_q[`LSA_N_BIT];
    flag_z_d = current_status_word_q[`LSA_Z_BIT];
    flag_c_d = c_flag;
    flag_v_d = v_flag;
    if (flag_up) begin
      flag_n_d = result[W-1];  // RQ10
      flag_z_d = (result == {W{1'b0}});  // RQ10
      flag_c_d = new_c;
      flag_v_d = new_v;
    end
  end
  always @* begin
    status_d = current_status_word_q;  // RQ8
    // Restore replaces the whole word, mode included
    if (restore) begin
      status_d = saved_status_word_i;  // RQ7
    end else begin
      status_d[`LSA_N_BIT] = flag_n_d;
      status_d[`LSA_Z_BIT] = flag_z_d;
      status_d[`LSA_C_BIT] = flag_c_d;
      status_d[`LSA_V_BIT] = flag_v_d;
    end
  end

  // ----------------------------------------
  // Next strobes
  // ----------------------------------------
  reg rd_we_d;
  reg pc_load_d;
  reg executed_d;
  reg unpredictable_d;
  always @* begin
    rd_we_d         = 1'b0;
    pc_load_d       = 1'b0;
    executed_d      = 1'b0;
    unpredictable_d = 1'b0;
    if (fire) begin
      executed_d = 1'b1;
      if (dest_pc) begin
        pc_load_d = 1'b1;  // RQ7 RQ8
        // Restoring form in a mode with no saved word
        unpredictable_d = set_fl & no_saved_word;  // RQ9
      end else begin
        rd_we_d = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      current_status_word_q <= `LSA_STATUS_RESET;
      current_status_word_o <= `LSA_STATUS_RESET;
    end else begin
      current_status_word_q <= status_d;  // RQ6
      current_status_word_o <= status_d;
    end
  end

  // ----------------------------------------
  // Strobe registers
  // ----------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_we_o         <= 1'b0;
      pc_load_o       <= 1'b0;
      executed_o      <= 1'b0;
      unpredictable_o <= 1'b0;
    end else begin
      rd_we_o         <= rd_we_d;  // RQ6
      pc_load_o       <= pc_load_d;
      executed_o      <= executed_d;
      unpredictable_o <= unpredictable_d;
    end
  end

  // ----------------------------------------
  // Register file write port
  // ----------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_index_o <= 4'h0;
      rd_data_o  <= {W{1'b0}};
    end else if (fire) begin
      rd_index_o <= rd_idx;
      rd_data_o  <= result;
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      program_counter_o <= `LSA_PC_RESET;
    end else if (restore | pc_load_d) begin
      program_counter_o <= result;  // RQ7 RQ8
    end
  end
endmodule // lsa_alu
`default_nettype wire

// [rtl/lsa_cond_check.v]
`timescale 1ns/100ps
`default_nettype none
`include "lsa_defines.vh"
// ----------------------------------------
// Condition field against N Z C V
// ----------------------------------------
module lsa_cond_check (
  // Inputs
  input  wire [3:0] cond_i,
  input  wire [3:0] nzcv_i,
  // Output
  output reg        pass_o
);
  wire n = nzcv_i[3];
  wire z = nzcv_i[2];
  wire c = nzcv_i[1];
  wire v = nzcv_i[0];
  always @* begin
    case (cond_i)
      4'h0:    pass_o = z;
      4'h1:    pass_o = ~z;
      4'h2:    pass_o = c;
      4'h3:    pass_o = ~c;
      4'h4:    pass_o = n;
      4'h5:    pass_o = ~n;
      4'h6:    pass_o = v;
      4'h7:    pass_o = ~v;
      4'h8:    pass_o = c & ~z;
      4'h9:    pass_o = ~c | z;
      4'ha:    pass_o = (n == v);
      4'hb:    pass_o = (n != v);
      4'hc:    pass_o = ~z & (n == v);
      4'hd:    pass_o = z | (n != v);
      4'he:    pass_o = 1'b1;
      default: pass_o = 1'b0;
    endcase
  end
endmodule // lsa_cond_check
`default_nettype wire

// [rtl/lsa_sub_unit.v]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// a - b - not(carry) with flags
// ----------------------------------------
module lsa_sub_unit #(
  parameter W = 32
) (
  // Operands
  input  wire [W-1:0] a_i,
  input  wire [W-1:0] b_i,
  input  wire         carry_i,
  // Results
  output wire [W-1:0] diff_o,
  output wire         no_borrow_o,
  output wire         ovf_o
);
  wire [W:0] sum;
  // a + ~b + carry equals a - b - not(carry)
  assign sum         = {1'b0, a_i} + {1'b0, ~b_i} + {{W{1'b0}}, carry_i};
  assign diff_o      = sum[W-1:0];
  assign no_borrow_o = sum[W];
  assign ovf_o       = (a_i[W-1] != b_i[W-1]) && (diff_o[W-1] != a_i[W-1]);
endmodule // lsa_sub_unit
`default_nettype wire

// [verification/lsa_alu_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module lsa_alu_chk #(parameter W = 32) (
  // Clock, reset and issue
  input wire         clock_i,
  input wire         rst_i,
  input wire         issue_i,
  input wire [31:0]  instr_i,
  input wire [W-1:0] shift_imm_operand_i,
  input wire [31:0]  saved_status_word_i,
  // Results
  input wire         rd_we_o,
  input wire [W-1:0] rd_data_o,
  input wire         pc_load_o,
  input wire [W-1:0] program_counter_o,
  input wire [31:0]  current_status_word_o,
  input wire         executed_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_mvn_imm; issue_i && instr_i[24:21] == 4'hf && instr_i[25]; endsequence
  sequence s_restore; issue_i && instr_i[20] && instr_i[15:12] == 4'hf; endsequence
  chk_no_issue: assert property (executed_o |-> $past(issue_i))
    else $error("result without issue");
  chk_one_target: assert property ((rd_we_o || pc_load_o) |-> executed_o && !(rd_we_o && pc_load_o))
    else $error("bad write target");
  chk_class_bits: assert property (issue_i && instr_i[27:26] != 2'h0 |=> !executed_o)
    else $error("wrong class executed");
  chk_never_cond: assert property (issue_i && instr_i[31:28] == 4'hf |=> !executed_o)
    else $error("never condition executed");
  chk_bad_opcode: assert property (issue_i && !(instr_i[24:21] inside {4'hf, 4'hc, 4'h3, 4'h7, 4'h6})
    |=> !executed_o)
    else $error("foreign opcode executed");
  chk_idle_hold: assert property (!executed_o |-> $stable(current_status_word_o) && $stable(program_counter_o))
    else $error("state moved when idle");
  chk_mvn_data: assert property (s_mvn_imm ##1 rd_we_o |-> rd_data_o == ~$past(shift_imm_operand_i))
    else $error("inverted move wrong");
  chk_restore: assert property (s_restore ##1 executed_o
    |-> pc_load_o && current_status_word_o == $past(saved_status_word_i))
    else $error("status not restored");
  chk_nz_flags: assert property (rd_we_o && $past(instr_i[20]) |-> current_status_word_o[31] == rd_data_o[31]
    && current_status_word_o[30] == (rd_data_o == 0))
    else $error("N or Z wrong");
  chk_pc_flags: assert property (pc_load_o && !$past(instr_i[20]) |-> $stable(current_status_word_o))
    else $error("flags moved on plain jump");
endmodule // lsa_alu_chk
`default_nettype wire

// [verification/lsa_alu_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module lsa_alu_tb;
  logic        clock_i = 0, rst_i = 1, issue_i = 0, ci, cr;
  logic [31:0] instr_i = 0, saved_i = 0, a, bi, br, st;
  logic [3:0]  ops [6] = '{4'hf, 4'hc, 4'h3, 4'h7, 4'h6, 4'h0};
  logic [3:0]  cds [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'he, 4'hf};
  wire         we, pcl, ex, unp;
  wire  [3:0]  ridx;
  wire  [31:0] rdat, pc, stat;
  int          fail_count = 0, n_tests = 0;
  always #50 clock_i = ~clock_i;
  lsa_shift_model i_model (.clock_i, .first_operand_register_o(a), .shift_imm_operand_o(bi),
    .shift_imm_carry_o(ci), .shift_reg_operand_o(br), .shift_reg_carry_o(cr));
  lsa_alu #(.W(32)) i_dut (.clock_i, .rst_i, .issue_i, .instr_i, .first_operand_register_i(a),
    .shift_imm_operand_i(bi), .shift_imm_carry_i(ci), .shift_reg_operand_i(br),
    .shift_reg_carry_i(cr), .saved_status_word_i(saved_i), .rd_we_o(we), .rd_index_o(ridx),
    .rd_data_o(rdat), .program_counter_o(pc), .pc_load_o(pcl), .current_status_word_o(stat),
    .executed_o(ex), .unpredictable_o(unp));
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic cond_ok(input logic [3:0] cd, input logic [31:0] s);
    case (cd)
      4'h0: cond_ok = s[30];
      4'h1: cond_ok = !s[30];
      4'h2: cond_ok = s[29];
      4'h3: cond_ok = !s[29];
      4'he: cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  endfunction
  // Result with new carry and overflow on top
  function automatic logic [33:0] calc(input logic [3:0] op, input logic [31:0] x, y,
                                       input logic csh, c, v);
    logic [32:0] s;
    logic [31:0] p, q;
    p = op == 4'h6 ? x : y;
    q = op == 4'h6 ? y : x;
    s = {1'b0, p} + {1'b0, ~q} + (op == 4'h3 ? 33'h1 : {32'h0, c});
    if (op == 4'hf) calc = {csh, v, ~y};
    else if (op == 4'hc) calc = {csh, v, x | y};
    else calc = {s[32], p[31] != q[31] && s[31] != p[31], s[31:0]};
  endfunction
  task automatic go(input logic [31:0] ins);
    logic [33:0] r;
    logic        ok;
    @(posedge clock_i);
    issue_i <= 1'b1;
    instr_i <= ins;
    @(negedge clock_i);
    r = calc(ins[24:21], a, ins[25] ? bi : br, ins[25] ? ci : cr, st[29], st[28]);
    ok = ins[27:26] == 2'h0 && ins[24:21] inside {4'hf, 4'hc, 4'h3, 4'h7, 4'h6}
         && cond_ok(ins[31:28], st);
    @(posedge clock_i);
    issue_i <= 1'b0;
    @(negedge clock_i);
    chk({31'h0, ex}, {31'h0, ok});
    if (ok) begin
      if (ins[20] && ins[15:12] == 4'hf) st = saved_i;
      else if (ins[20]) st[31:28] = {r[31], r[31:0] == 0, r[33:32]};
      chk(ins[15:12] == 4'hf ? pc : rdat, r[31:0]);
      chk({31'h0, ins[15:12] == 4'hf ? pcl : we}, 32'h1);
      chk({28'h0, ridx}, {28'h0, ins[15:12]});
      chk({31'h0, unp}, 32'h0);
    end
    chk(stat, st);
  endtask
  initial begin
    logic [31:0] r;
    logic [3:0]  op;
    void'($urandom(87560));
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    st = 32'h000000d3;
    chk(stat, st);
    chk(pc, 32'h0);
    go(32'he1f0f000);
    go(32'hf1900000);
    go(32'he4000000);
    repeat (600) begin
      r = $urandom;
      op = ops[$urandom_range(5)];
      saved_i <= {r[31:28], 23'h0, 5'h13};
      go({cds[$urandom_range(5)], 2'h0, r[25], op, r[20],
          op == 4'hf ? 4'h0 : r[19:16], r[15:0]});
    end
    report_and_stop;
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop;
  end
endmodule // lsa_alu_tb
bind lsa_alu lsa_alu_chk #(.W(W)) u_chk (.clock_i, .rst_i, .issue_i, .instr_i,
  .shift_imm_operand_i, .saved_status_word_i, .rd_we_o, .rd_data_o, .pc_load_o,
  .program_counter_o, .current_status_word_o, .executed_o);
`default_nettype wire

// [verification/lsa_shift_model.sv]
`timescale 1ns/100ps
`default_nettype none
// --------
// Register file and operand shifter
// --------
module lsa_shift_model (
  // Clock
  input  wire         clock_i,
  // Operands
  output logic [31:0] first_operand_register_o,
  output logic [31:0] shift_imm_operand_o,
  output logic        shift_imm_carry_o,
  output logic [31:0] shift_reg_operand_o,
  output logic        shift_reg_carry_o
);
  function automatic logic [31:0] pick();
    logic [31:0] r;
    r = $urandom;
    // Zero and sign-edge values often
    pick = r[1:0] == 2'h0 ? 32'h0 : r[1:0] == 2'h1 ? {r[2], {31{~r[2]}}} : $urandom;
  endfunction
  initial {first_operand_register_o, shift_imm_operand_o, shift_reg_operand_o} = '0;
  initial {shift_imm_carry_o, shift_reg_carry_o} = 2'h0;
  // Fresh values every cycle, never a stale copy
  always @(posedge clock_i) begin
    first_operand_register_o <= pick();
    shift_imm_operand_o      <= pick();
    shift_reg_operand_o      <= pick();
    {shift_imm_carry_o, shift_reg_carry_o} <= 2'($urandom);
  end
endmodule // lsa_shift_model
`default_nettype wire
